// file: core/scw_unit.v
// Stepper control-word unit: APB register slave, control word interpreter,
// small profile command queue, step pulse generator with accel/decel ramp.
// Assumes one 50 MHz clock, synchronous active-high reset, an APB master.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "scw_defines.vh"

module scw_unit (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Motor driver
	output reg         step_output,
	output reg         dir_ccw_output,
	// Interrupt
	output reg         irq
);

	reg  [15:0] control_word_number;
	reg         cw_pending;
	reg         prof_en;
	reg         paused;
	reg         mode_cwccw;
	reg         last_illegal;
	reg         stop_pend;
	reg         moving;
	reg         decel;
	reg         dir_fwd;
	reg  [15:0] remain;
	reg  [15:0] cur_per;
	reg  [15:0] per_cnt;
	reg  [15:0] pulse_cnt;
	reg         pulse_on;
	reg  [15:0] rate;
	reg  [15:0] acc;
	reg  [4:0]  istat;
	reg  [4:0]  imask;
	reg  [16:0] q_mem [0:3];
	reg  [1:0]  q_wr;
	reg  [1:0]  q_rd;
	reg  [2:0]  q_cnt;
	reg  [31:0] rd_data;
	reg         rd_ok;

	// Bus decode
	wire        acc_phase = psel & penable & pready;
	wire        bus_wr    = acc_phase & pwrite;
	wire [7:0]  a         = paddr[7:0];
	wire        hi_zero   = (paddr[31:8] == 24'h000000);
	wire        wr_cw     = bus_wr & hi_zero & (a == `SCW_A_CTRL);
	wire        wr_cmd    = bus_wr & hi_zero & (a == `SCW_A_CMD);
	wire        wr_istat  = bus_wr & hi_zero & (a == `SCW_A_ISTAT);

	// Control word decode, valid in the single processing cycle
	wire cw_en    = cw_pending & (control_word_number == `SCW_CW_ENABLE);
	wire cw_pause = cw_pending & (control_word_number == `SCW_CW_PAUSE);
	wire cw_cont  = cw_pending & (control_word_number == `SCW_CW_CONT);
	wire cw_estop = cw_pending & (control_word_number == `SCW_CW_ESTOP);
	wire cw_cstop = cw_pending & (control_word_number == `SCW_CW_CSTOP);
	wire cw_sd    = cw_pending & (control_word_number == `SCW_CW_STEPDIR);
	wire cw_cc    = cw_pending & (control_word_number == `SCW_CW_CWCCW);
	wire cw_bad   = cw_pending & ((control_word_number == `SCW_CW_NONE) |
	                (control_word_number > `SCW_CW_CWCCW));

	// Queue
	wire        q_full = (q_cnt == `SCW_Q_DEPTH);
	wire        q_none = (q_cnt == `SCW_Q_EMPTY);
	wire [16:0] q_head = q_mem[q_rd];
	wire        cmd_ok = (pwdata[15:0] != `SCW_STEPS_ZERO);
	wire        push   = wr_cmd & cmd_ok & prof_en & ~q_full;
	wire        ovf    = wr_cmd & cmd_ok & prof_en & q_full;

	// Conditions that drop the enable at once and kill pulses
	wire kill = cw_estop | cw_bad | ovf;

	// Motion timing
	wire tick      = moving & (per_cnt >= cur_per);
	wire last_step = tick & ~decel & (remain == `SCW_STEPS_ONE);
	wire [16:0] per_up = {1'b0, cur_per} + {1'b0, acc};
	wire decel_end = tick & decel & (per_up >= {1'b0, `SCW_START_PER});

	// Continue while moving abandons the current command for the next one
	wire hop   = cw_cont & moving & ~q_none;
	// Pause only holds off new starts; a running move is left alone
	wire go_ok = (~paused | cw_cont) & ~cw_pause & ~decel;
	wire start = ~kill & ~cw_cstop & prof_en & ~q_none &
	             (hop | (go_ok & (~moving | last_step)));
	wire halt  = moving & ~start & (kill | decel_end | last_step);

	// Sticky event sources: done, illegal, queue empty, stopped, overflow
	wire       empty_ev = (cw_cont & q_none) | (last_step & q_none);
	wire [4:0] ev        = {ovf, halt, empty_ev, cw_bad, cw_pending};
	wire [4:0] clr       = wr_istat ? pwdata[4:0] : 5'h00;
	// Set wins over a clear in the same cycle
	wire [4:0] next_istat = (istat & ~clr) | ev;

	wire [31:0] status_word = {16'h0000, 4'h0, 1'b0, q_cnt, last_illegal,
	                           mode_cwccw, decel, moving, q_none, paused,
	                           cw_pending, prof_en};

	// Read mux and address check
	always @* begin
		rd_data = 32'h00000000;
		rd_ok   = 1'b1;
		if (!hi_zero) begin
			rd_ok = 1'b0;
		end else if (a == `SCW_A_CTRL) begin
			rd_data = {16'h0000, control_word_number};
		end else if (a == `SCW_A_STATUS) begin
			rd_data = status_word;
		end else if (a == `SCW_A_CMD) begin
			rd_data = 32'h00000000;
		end else if (a == `SCW_A_RATE) begin
			rd_data = {16'h0000, rate};
		end else if (a == `SCW_A_ACC) begin
			rd_data = {16'h0000, acc};
		end else if (a == `SCW_A_ISTAT) begin
			rd_data = {27'h0000000, istat};
		end else if (a == `SCW_A_IMASK) begin
			rd_data = {27'h0000000, imask};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Queue storage needs no reset; only the q_cnt entries starting at q_rd are ever read
	always @(posedge clk) begin
		if (push) begin
			q_mem[q_wr] <= pwdata[16:0];
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			prdata              <= 32'h00000000;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			control_word_number <= `SCW_CW_NONE;
			cw_pending          <= 1'b0;
			prof_en             <= 1'b0;
			paused              <= 1'b0;
			mode_cwccw          <= 1'b0;
			last_illegal        <= 1'b0;
			stop_pend           <= 1'b0;
			moving              <= 1'b0;
			decel               <= 1'b0;
			dir_fwd             <= 1'b1;
			remain              <= `SCW_STEPS_ZERO;
			cur_per             <= `SCW_START_PER;
			per_cnt             <= 16'h0000;
			pulse_cnt           <= 16'h0000;
			pulse_on            <= 1'b0;
			rate                <= `SCW_RATE_RST;
			acc                 <= `SCW_ACC_RST;
			istat               <= 5'h00;
			imask               <= `SCW_IMASK_RST;
			q_wr                <= 2'h0;
			q_rd                <= 2'h0;
			q_cnt               <= `SCW_Q_EMPTY;
			step_output         <= 1'b0;
			dir_ccw_output      <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			// No wait state; read data is registered in the setup cycle so it comes from a flop
			pready <= psel & ~penable & ~pready;
			if (psel & ~penable) begin
				prdata  <= rd_data;
				pslverr <= ~rd_ok;
			end else if (acc_phase) begin
				prdata  <= 32'h00000000;
				pslverr <= 1'b0;
			end

			// Control word intake; writes while pending are dropped
			if (wr_cw & ~cw_pending) begin
				control_word_number <= pwdata[15:0];
				cw_pending          <= 1'b1;
			end else if (cw_pending) begin
				cw_pending <= 1'b0;
			end
			if (cw_pending) begin
				last_illegal <= cw_bad;
			end
			if (cw_en) begin
				prof_en <= 1'b1;
			end
			if (cw_pause) begin
				paused <= 1'b1;
			end
			if (cw_cont) begin
				paused <= 1'b0;
			end
			if (cw_sd) begin
				mode_cwccw <= 1'b0;
			end
			if (cw_cc) begin
				mode_cwccw <= 1'b1;
			end
			if (kill | (stop_pend & decel_end) | (cw_cstop & ~moving)) begin
				prof_en <= 1'b0;
			end
			if (kill | halt) begin
				stop_pend <= 1'b0;
			end else if (cw_cstop & moving) begin
				stop_pend <= 1'b1;
			end

			// Queue pointers; a flush beats a push in the same cycle
			if (kill | cw_cstop | ~prof_en) begin
				q_wr  <= 2'h0;
				q_rd  <= 2'h0;
				q_cnt <= `SCW_Q_EMPTY;
			end else begin
				if (push) begin
					q_wr <= q_wr + 2'h1;
				end
				if (start) begin
					q_rd <= q_rd + 2'h1;
				end
				if (push & ~start) begin
					q_cnt <= q_cnt + 3'h1;
				end else if (start & ~push) begin
					q_cnt <= q_cnt - 3'h1;
				end
			end

			// Period ramp: shorten toward rate, lengthen while decelerating
			per_cnt <= (moving & ~tick) ? per_cnt + 16'h0001 : 16'h0000;
			if (tick) begin
				if (decel) begin
					cur_per <= per_up[15:0];
				end else if ({1'b0, cur_per} > {1'b0, rate} + {1'b0, acc}) begin
					cur_per <= cur_per - acc;
				end else begin
					cur_per <= rate;
				end
			end

			// Command sequencing
			if (start) begin
				moving  <= 1'b1;
				decel   <= 1'b0;
				remain  <= q_head[15:0];
				dir_fwd <= ~q_head[16];
				per_cnt <= 16'h0000;
				if (!moving) begin
					cur_per <= `SCW_START_PER;
				end
			end else if (halt) begin
				moving <= 1'b0;
				decel  <= 1'b0;
			end else begin
				if (moving & (cw_cstop | (cw_cont & q_none))) begin
					decel <= 1'b1;
				end
				if (tick & ~decel) begin
					remain <= remain - `SCW_STEPS_ONE;
				end
			end

			// Step pulse shaping; an emergency stop cuts the pulse short
			if (kill) begin
				pulse_on <= 1'b0;
			end else if (tick & ~decel_end) begin
				pulse_on  <= 1'b1;
				pulse_cnt <= 16'h0000;
			end else if (pulse_on) begin
				if ({16'h0000, pulse_cnt} == `SCW_PULSE_CYC - 1) begin
					pulse_on <= 1'b0;
				end
				pulse_cnt <= pulse_cnt + 16'h0001;
			end

			// Output pins
			if (mode_cwccw) begin
				step_output    <= pulse_on & dir_fwd;
				dir_ccw_output <= pulse_on & ~dir_fwd;
			end else begin
				step_output    <= pulse_on;
				dir_ccw_output <= ~dir_fwd;
			end

			// Configuration and interrupts
			if (bus_wr & hi_zero & (a == `SCW_A_RATE)) begin
				rate <= pwdata[15:0];
			end
			if (bus_wr & hi_zero & (a == `SCW_A_ACC)) begin
				acc <= pwdata[15:0];
			end
			if (bus_wr & hi_zero & (a == `SCW_A_IMASK)) begin
				imask <= pwdata[4:0];
			end
			istat <= next_istat;
			irq   <= |(next_istat & imask);
		end
	end

endmodule // scw_unit

// file: common/scw_defines.vh
// Constants of the stepper control-word unit: APB offsets, control word codes,
// queue size, reset values and timing. Assumes a 50 MHz module clock.
`ifndef SCW_DEFINES_VH
`define SCW_DEFINES_VH

// APB byte offsets (low address byte; upper bits must be zero)
`define SCW_A_CTRL   8'h00
`define SCW_A_STATUS 8'h04
`define SCW_A_CMD    8'h08
`define SCW_A_RATE   8'h0C
`define SCW_A_ACC    8'h10
`define SCW_A_ISTAT  8'h14
`define SCW_A_IMASK  8'h18

// Control word numbers
`define SCW_CW_NONE   16'h0000
`define SCW_CW_ENABLE 16'h0001
`define SCW_CW_PAUSE  16'h0002
`define SCW_CW_CONT   16'h0003
`define SCW_CW_ESTOP  16'h0004
`define SCW_CW_CSTOP  16'h0005
`define SCW_CW_STEPDIR 16'h0006
`define SCW_CW_CWCCW  16'h0007

// Command queue
`define SCW_Q_DEPTH  3'h4
`define SCW_Q_EMPTY  3'h0
`define SCW_STEPS_ONE 16'h0001
`define SCW_STEPS_ZERO 16'h0000

// Reset values
`define SCW_RATE_RST 16'h03E8
`define SCW_ACC_RST  16'h0010
`define SCW_IMASK_RST 5'h00

// Step period at standstill, in clock cycles
`define SCW_START_PER 16'h4E20

// Step pulse width
`define SCW_CLK_NS    20
`define SCW_PULSE_NS  2000
`define SCW_PULSE_CYC ((`SCW_PULSE_NS + `SCW_CLK_NS - 1) / `SCW_CLK_NS)

`endif

// file: verif/scw_unit_properties.sv
// Port-level checks of scw_unit, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module scw_chk (
	// Clock and reset
	input wire        clk,
	input wire        rst,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Motor and interrupt
	input wire        step_output,
	input wire        dir_ccw_output,
	input wire        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire acc = psel && penable && pready && pwrite;
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_err_pair: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not cleared");
	chk_high_addr: assert property (psel && !penable && paddr[31:8] != 24'h0 |=> pslverr)
		else $error("high address not refused");
	chk_reset_out: assert property (disable iff (1'b0) rst |=> !pready && !step_output && !irq)
		else $error("outputs active in reset");
	chk_pulse_min: assert property ($rose(step_output) |=> step_output[*8])
		else $error("step pulse too short");
	chk_estop_cut: assert property (acc && paddr == 32'h0 && pwdata[15:0] == 16'h0004
		|-> ##[1:4] !step_output[*8]) else $error("pulses after emergency stop");
endmodule // scw_chk
bind scw_unit scw_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .step_output(step_output), .dir_ccw_output(dir_ccw_output), .irq(irq));

// file: verif/scw_driver_model.sv
// Motor driver model: counts rising edges on both driver inputs.
// Assumes the bench waits on reverse counts only in CW/CCW mode.
`timescale 1ns/1ps
module scw_driver_model (
	// Clock
	input  wire        clk,
	// Driver inputs
	input  wire        step_output,
	input  wire        dir_ccw_output,
	// Edge counts
	output reg  [15:0] fwd,
	output reg  [15:0] rev
);
	reg last_s = 1'b0;
	reg last_d = 1'b0;
	initial fwd = 16'h0000;
	initial rev = 16'h0000;
	// Edges, not levels: a long pulse still counts as one step
	always @(posedge clk) begin
		last_s <= step_output;
		last_d <= dir_ccw_output;
		if (step_output && !last_s)
			fwd <= fwd + 16'h0001;
		if (dir_ccw_output && !last_d)
			rev <= rev + 16'h0001;
	end
endmodule // scw_driver_model

// file: verif/scw_unit_test.sv
// Directed bench for scw_unit over APB, with the driver model on the pins.
// Assumes the checker bind is compiled alongside.
`timescale 1ns/1ps
`include "scw_defines.vh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module scw_unit_test;
	reg         clk, rst, psel, penable, pwrite, er;
	reg  [31:0] paddr, pwdata, rd;
	wire [31:0] prdata;
	wire        pready, pslverr, step_output, dir_ccw_output, irq;
	wire [15:0] fwd, rev;
	int         num_errors, n_compared, k, j;
	scw_unit u_scw_unit (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_output(step_output), .dir_ccw_output(dir_ccw_output), .irq(irq));
	scw_driver_model u_scw_driver_model (.clk(clk), .step_output(step_output),
		.dir_ccw_output(dir_ccw_output), .fwd(fwd), .rev(rev));
	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, num_errors);
			if (num_errors == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (pready !== 1'b1 && k < 16);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (k >= 16) begin
				num_errors++;
				summarize;
			end
		end
	endtask
	// Polls pending before anything else may be written
	task cw(input logic [15:0] n);
		begin
			apb(1'b1, 32'h0, {16'h0000, n});
			j = 0;
			do begin
				apb(1'b0, 32'h4, 32'h0);
				j++;
			end while (rd[1] !== 1'b0 && j < 8);
			`CHK("cw latency", 1'b1, j == 1)
			if (rd[1] !== 1'b0)
				summarize;
		end
	endtask
	task wait_n(input logic r, input logic [15:0] n);
		begin
			k = 0;
			while ((r ? rev : fwd) !== n && k < 22000) begin
				@(posedge clk);
				k++;
			end
			`CHK("pulse count", n, r ? rev : fwd)
			if ((r ? rev : fwd) !== n)
				summarize;
		end
	endtask
	task t_reset;
		begin
			apb(1'b0, 32'h4, 32'h0);
			`CHK("status", 32'h00000008, rd)
			apb(1'b0, 32'hC, 32'h0);
			`CHK("rate", 32'h000003E8, rd)
			apb(1'b0, 32'h1C, 32'h0);
			`CHK("unmapped", 1'b1, er)
			apb(1'b0, 32'h100, 32'h0);
			`CHK("high addr", 1'b1, er)
			$display("t_reset done");
		end
	endtask
	task t_move;
		begin
			apb(1'b1, 32'h8, 32'h2);
			apb(1'b0, 32'h4, 32'h0);
			`CHK("queue off", 3'h0, rd[10:8])
			apb(1'b1, 32'hC, 32'hC8);
			// ACC of a full start period: cruise after one step, stop on the next
			apb(1'b1, 32'h10, 32'h4E20);
			cw(`SCW_CW_ENABLE);
			`CHK("enabled", 1'b1, rd[0])
			apb(1'b1, 32'h8, 32'h2);
			wait_n(1'b0, 16'h0002);
			`CHK("dir level", 16'h0000, rev)
			$display("t_move done");
		end
	endtask
	task t_ccw;
		begin
			cw(`SCW_CW_PAUSE);
			`CHK("paused", 1'b1, rd[2])
			cw(`SCW_CW_CONT);
			`CHK("resumed", 2'b10, rd[3:2])
			cw(`SCW_CW_CWCCW);
			`CHK("ccw mode", 1'b1, rd[6])
			apb(1'b1, 32'h8, 32'h10001);
			wait_n(1'b1, 16'h0001);
			`CHK("no fwd", 16'h0002, fwd)
			$display("t_ccw done");
		end
	endtask
	task t_estop;
		begin
			apb(1'b1, 32'h8, 32'hFFFF);
			wait_n(1'b0, 16'h0003);
			// Let the pulse end first; cutting a pulse short is the stop's own effect
			repeat (120) @(posedge clk);
			cw(`SCW_CW_ESTOP);
			`CHK("disabled", 1'b0, rd[0])
			`CHK("flushed", 3'h0, rd[10:8])
			repeat (400) @(posedge clk);
			`CHK("halted", 16'h0003, fwd)
			$display("t_estop done");
		end
	endtask
	task t_illegal;
		begin
			apb(1'b1, 32'h18, 32'h2);
			`CHK("irq masked", 1'b0, irq)
			cw(16'h0009);
			`CHK("illegal", 2'b11, rd[7:6])
			`CHK("irq", 1'b1, irq)
			apb(1'b1, 32'h14, 32'h1F);
			repeat (2) @(posedge clk);
			`CHK("irq clear", 1'b0, irq)
			$display("t_illegal done");
		end
	endtask
	task t_flow;
		begin
			cw(`SCW_CW_STEPDIR);
			`CHK("stepdir mode", 1'b0, rd[6])
			cw(`SCW_CW_ENABLE);
			cw(`SCW_CW_PAUSE);
			apb(1'b1, 32'h8, 32'hFFFF);
			apb(1'b0, 32'h4, 32'h0);
			`CHK("held off", 4'h2, ({rd[10:8], rd[4]}))
			cw(`SCW_CW_CONT);
			`CHK("run after cont", 4'h1, ({rd[10:8], rd[4]}))
			wait_n(1'b0, 16'h0004);
			apb(1'b1, 32'h8, 32'h1FFFF);
			cw(`SCW_CW_PAUSE);
			wait_n(1'b0, 16'h0006);
			`CHK("dir fwd", 1'b0, dir_ccw_output)
			cw(`SCW_CW_CONT);
			`CHK("hop dir", 1'b1, dir_ccw_output)
			`CHK("hop queue", 4'h1, ({rd[10:8], rd[4]}))
			wait_n(1'b0, 16'h0007);
			`CHK("hop speed", 1'b1, k < 400)
			apb(1'b1, 32'h8, 32'h5);
			cw(`SCW_CW_CSTOP);
			`CHK("ramping", 6'h07, ({rd[10:8], rd[5:4], rd[0]}))
			repeat (300) @(posedge clk);
			apb(1'b0, 32'h4, 32'h0);
			`CHK("cstop done", 3'h0, ({rd[5:4], rd[0]}))
			$display("t_flow done");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_move;
		t_ccw;
		t_estop;
		t_illegal;
		t_flow;
		summarize;
	end
endmodule // scw_unit_test
